// [src/usb_out_ep_pkg.sv]
// Purpose: Shared constants and state types of the OUT endpoint receive control.
// Assumes: Four OUT endpoints, 16-bit registers in the low half of 32-bit APB words.
// Notes:   Register byte address = endpoint * 16 + register offset.
package usb_out_ep_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NumEp  = 4;       // Endpoints 1 to 4 map to indices 0 to 3.
  localparam int CntW   = 11;      // Byte count width.
  localparam int AddrW  = 12;      // FIFO byte address width (4096-byte space).
  localparam int UnitSh = 6;       // Layout fields count in 64-byte units.
  localparam logic [CntW-1:0] SizeZeroBytes = 11'h400; // Size code 0 means 1024 bytes.

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MapLimit = 8'h40;  // First unmapped byte address.
  localparam int         EpSelHi  = 5;      // Address bits that select the endpoint.
  localparam int         EpSelLo  = 4;
  localparam logic [3:0] RegCtrl  = 4'h0;   // out_endpoint_control_status.
  localparam logic [3:0] RegMaxp  = 4'h4;   // out_endpoint_max_packet_size.
  localparam logic [3:0] RegCount = 4'h8;   // out_endpoint_received_byte_count.
  localparam logic [3:0] RegLay   = 4'hc;   // out_endpoint_fifo_layout.

  // Control and status bit positions.
  localparam int BitOccLow   = 0;   // occupancy_flag_low, read only.
  localparam int BitOccHigh  = 1;   // occupancy_flag_high, read only.
  localparam int BitOverrun  = 2;   // Receive lost flag, read only.
  localparam int BitOversize = 3;   // Packet size error flag, read only.
  localparam int BitDataErr  = 4;   // Stuff or CRC fault flag, read only.
  localparam int BitRelease  = 5;   // buffer_release_bit, write one, reads zero.
  localparam int BitClrOvr   = 6;   // receive_lost_clear_bit.
  localparam int BitClrSize  = 7;   // oversize_clear_bit.
  localparam int BitClrErr   = 8;   // stuff_crc_fault_clear_bit.
  localparam int BitTogInit  = 9;   // Toggle initialise, self clearing.
  localparam int BitDiscard  = 10;  // Discard one buffer, self clearing.
  localparam int BitIso      = 11;  // Transfer type, one means isochronous.
  localparam int BitStall    = 12;  // Forced stall.
  localparam int BitAutoRel  = 13;  // implicit_release_enable.
  localparam int BitToggle   = 14;  // Expected data toggle, read only.

  // Layout field positions.
  localparam int LayStartLo = 0;
  localparam int LayStartHi = 5;
  localparam int LaySizeLo  = 6;
  localparam int LaySizeHi  = 9;
  localparam int LayDouble  = 10;   // two_buffer_enable.
  localparam int LayCont    = 11;   // Continuous bulk receive.

  // ---------------------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] HsAck   = 2'h1;
  localparam logic [1:0] HsNak   = 2'h2;
  localparam logic [1:0] HsStall = 2'h3;
  localparam logic [1:0] OccEmpty = 2'h0;  // {high, low} = 00.
  localparam logic [1:0] OccOne   = 2'h2;  // 10, one buffer of two.
  localparam logic [1:0] OccFull  = 2'h3;  // 11.
  localparam logic [1:0] NBufZero = 2'h0;
  localparam logic [1:0] NBufOne  = 2'h1;
  localparam logic [1:0] NBufTwo  = 2'h2;

  // Per-endpoint state.
  typedef struct packed {
    logic [1:0]      nBuf;        // Buffers held, 0 to 2.
    logic [CntW-1:0] cnt0;        // Byte count of the older buffer.
    logic [CntW-1:0] cnt1;        // Byte count of the newer buffer.
    logic [CntW-1:0] wrCnt;       // Bytes gathered in the open buffer.
    logic [CntW-1:0] rdCnt;       // Bytes read from the oldest buffer.
    logic            wrSel;       // Physical buffer being filled.
    logic [CntW-1:0] maxp;        // Maximum packet size.
    logic            overrun;
    logic            oversize;
    logic            dataErr;
    logic            iso;
    logic            forceStall;
    logic            autoRel;
    logic            toggle;      // Expected data toggle, 0 means DATA0.
    logic            togInitPend;
    logic            discardPend;
    logic [5:0]      start;
    logic [3:0]      size;
    logic            dbl;
    logic            cont;
  } ep_s;

endpackage : usb_out_ep_pkg

// [src/usb_out_endpoint_receive_ctrl.sv]
// Purpose: Receive control of four USB OUT endpoints with an APB register slave.
// Assumes: Link-side events come from packet logic on clk; one packet event per cycle.
// Notes:   Packet data itself lives in an external FIFO RAM; this block steers it.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// R1: Oversize packet sets packet size error flag.
// R2: Size error blocks data; bulk answers STALL.
// R3: Write one to clear bits clears flag.
// R4: Isochronous stuff or CRC fault sets error.
// R5: Release bit frees buffer, updates occupancy.
// R6: Toggle initialise expects DATA0, resets counters.
// R7: Toggle initialise bit clears itself when done.
// R8: Software initialises toggle before OUT traffic.
// R9: Discard with one buffer empties FIFO.
// R10: Discard with two buffers drops older one.
// R11: Discard bit clears itself after dropping.
// R12: Transfer type bit selects isochronous or bulk.
// R13: Forced stall answers every bulk OUT STALL.
// R14: Implicit release frees buffer once fully read.
// R15: Maximum packet size resets to zero.
// R16: Byte count loads when buffer completes.
// R17: Byte count holds while FIFO is read.
// R18: Two buffers: count shows older, then next.
// R19: Start field places FIFO in 64-byte steps.
// R20: Size field sets buffer length, doubled optionally.
// R21: Continuous bulk fills buffer until full or short.
// R22: Software keeps FIFOs inside space, non-overlapping.
// R23: Occupancy codes 00 empty, 10 one, 11 full.
// R24: Isochronous OUT into occupied FIFO sets overrun.
// R25: Writing zero to clear bits changes nothing.
module usb_out_endpoint_receive_ctrl (
  input  wire logic        clk,          // 25 MHz system clock.
  input  wire logic        rstn,         // Asynchronous reset, active low.
  input  wire logic        ce,           // Clock enable; low freezes all state.
  input  wire logic        psel,         // APB select.
  input  wire logic        penable,      // APB access phase.
  input  wire logic        pwrite,       // APB direction, high for write.
  input  wire logic [7:0]  paddr,        // APB byte address.
  input  wire logic [31:0] pwdata,       // APB write data.
  input  wire logic [3:0]  pstrb,        // APB byte strobes.
  output logic      [31:0] prdata,       // APB read data.
  output logic             pready,       // APB ready.
  output logic             pslverr,      // APB error for unmapped addresses.
  input  wire logic        rxValid,      // Pulse: one OUT packet has ended.
  input  wire logic [1:0]  rxEp,         // Endpoint index of that packet.
  input  wire logic        rxToggle,     // Data toggle of the packet, 0 for DATA0.
  input  wire logic [10:0] rxBytes,      // Payload length of the packet.
  input  wire logic        rxBad,        // Stuffing or CRC fault seen in the packet.
  input  wire logic        fifoRead,     // Pulse: software read one FIFO byte.
  input  wire logic [1:0]  fifoReadEp,   // Endpoint of that read.
  output logic             hsValid,      // Pulse: send the handshake below.
  output logic      [1:0]  hsCode,       // Handshake: ACK, NAK or STALL.
  output logic             storeValid,   // Pulse: write the packet into the FIFO RAM.
  output logic      [1:0]  storeEp,      // Endpoint being stored.
  output logic      [11:0] storeAddr,    // First FIFO byte address of the store.
  output logic      [10:0] storeLen      // Bytes to store.
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    usb_out_ep_pkg::ep_s [usb_out_ep_pkg::NumEp-1:0] ep;  // Per-endpoint state.
    logic [31:0]                   prdata;     // Read data held for the bus.
    logic                          pready;     // Ready, one wait state per access.
    logic                          pslverr;    // Error answer.
    logic                          hsValid;    // Handshake strobe.
    logic [1:0]                    hsCode;     // Handshake code.
    logic                          storeValid; // Store strobe.
    logic [1:0]                    storeEp;    // Store endpoint.
    logic [usb_out_ep_pkg::AddrW-1:0] storeAddr; // Store address.
    logic [usb_out_ep_pkg::CntW-1:0]  storeLen;  // Store length.
  } state_s;

  state_s s_q;   // Registered state.
  state_s s_d;   // Next state.

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Occupancy code from the buffer count; single-buffer mode never shows 10.
  function automatic logic [1:0] occ_code(input logic [1:0] n, input logic dbl);
    logic [1:0] c;
    c = usb_out_ep_pkg::OccFull;
    if (n == usb_out_ep_pkg::NBufZero) begin
      c = usb_out_ep_pkg::OccEmpty;                        // R23
    end else if (dbl && n == usb_out_ep_pkg::NBufOne) begin
      c = usb_out_ep_pkg::OccOne;                          // R23
    end
    return c;
  endfunction : occ_code

  // Bytes of one buffer; a size code of zero stands for the 1024-byte maximum.
  function automatic logic [10:0] buf_bytes(input logic [3:0] size);
    logic [10:0] b;
    b = usb_out_ep_pkg::SizeZeroBytes;
    if (size != 4'h0) begin
      b = 11'({7'h00, size} << usb_out_ep_pkg::UnitSh);   // R20
    end
    return b;
  endfunction : buf_bytes

  // Bus decode shared by the whole next-state process.
  logic        mapped;   // Address falls inside the register window.
  logic [3:0]  regSel;   // Register offset within the endpoint.
  logic [1:0]  regEp;    // Endpoint selected by the address.
  logic        wrAcc;    // Write completing at this edge.
  logic [15:0] wMask;    // Byte-lane mask for the 16 implemented bits.
  logic [15:0] wd;       // Write data under the lane mask.

  assign mapped = (paddr < usb_out_ep_pkg::MapLimit);
  assign regSel = {paddr[3:2], 2'b00};
  assign regEp  = paddr[usb_out_ep_pkg::EpSelHi:usb_out_ep_pkg::EpSelLo];
  assign wrAcc  = psel && penable && s_q.pready && pwrite && mapped;
  assign wMask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wd     = pwdata[15:0] & wMask;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // All endpoints are evaluated in one loop so each sees the same bus and link
  // inputs; only the endpoint whose index matches reacts to an event.
  always_comb begin
    usb_out_ep_pkg::ep_s cur;
    usb_out_ep_pkg::ep_s nxt;
    logic [15:0]  rd;
    logic         ctrlW, relW, clrOvr, clrSize, clrErr;
    logic         setOvr, setSize, setErr, push, pop, full, mine;
    logic [11:0]  sum;
    logic [10:0]  bufLen, len;
    logic [11:0]  base;
    cur = '0;
    nxt = '0;
    rd = '0;
    ctrlW = 1'b0; relW = 1'b0; clrOvr = 1'b0; clrSize = 1'b0; clrErr = 1'b0;
    setOvr = 1'b0; setSize = 1'b0; setErr = 1'b0; push = 1'b0; pop = 1'b0;
    full = 1'b0; mine = 1'b0;
    sum = '0; bufLen = '0; len = '0; base = '0;
    s_d = s_q;
    s_d.hsValid    = 1'b0;
    s_d.storeValid = 1'b0;

    // One wait state: ready rises in the first access cycle and completes the
    // transfer in the second, which gives time to register the read data.
    s_d.pready  = psel && penable && !s_q.pready;
    s_d.pslverr = s_d.pready && !mapped;
    s_d.prdata  = '0;

    for (int e = 0; e < usb_out_ep_pkg::NumEp; e++) begin
      cur = s_q.ep[e];
      nxt = cur;
      ctrlW = wrAcc && (regEp == 2'(e)) && (regSel == usb_out_ep_pkg::RegCtrl);
      relW    = ctrlW && wd[usb_out_ep_pkg::BitRelease];
      clrOvr  = ctrlW && wd[usb_out_ep_pkg::BitClrOvr];     // R3 R25
      clrSize = ctrlW && wd[usb_out_ep_pkg::BitClrSize];    // R3 R25
      clrErr  = ctrlW && wd[usb_out_ep_pkg::BitClrErr];     // R3 R25
      setOvr = 1'b0; setSize = 1'b0; setErr = 1'b0; push = 1'b0; pop = 1'b0;
      bufLen = buf_bytes(cur.size);
      full   = (cur.nBuf == (cur.dbl ? usb_out_ep_pkg::NBufTwo : usb_out_ep_pkg::NBufOne));

      // Register writes; read-write fields honour the byte lanes.
      if (ctrlW) begin
        nxt.iso        = wMask[usb_out_ep_pkg::BitIso]
                       ? wd[usb_out_ep_pkg::BitIso] : cur.iso;       // R12
        nxt.forceStall = wMask[usb_out_ep_pkg::BitStall]
                       ? wd[usb_out_ep_pkg::BitStall] : cur.forceStall;  // R13
        nxt.autoRel    = wMask[usb_out_ep_pkg::BitAutoRel]
                       ? wd[usb_out_ep_pkg::BitAutoRel] : cur.autoRel;   // R14
      end else if (wrAcc && regEp == 2'(e) && regSel == usb_out_ep_pkg::RegMaxp) begin
        nxt.maxp = (cur.maxp & ~wMask[10:0]) | wd[10:0];
      end else if (wrAcc && regEp == 2'(e) && regSel == usb_out_ep_pkg::RegLay) begin
        nxt.start = (cur.start & ~wMask[5:0]) | wd[5:0];                 // R19
        nxt.size  = (cur.size & ~wMask[9:6]) | wd[9:6];                  // R20
        nxt.dbl   = wMask[usb_out_ep_pkg::LayDouble] ? wd[usb_out_ep_pkg::LayDouble] : cur.dbl;
        nxt.cont  = wMask[usb_out_ep_pkg::LayCont] ? wd[usb_out_ep_pkg::LayCont] : cur.cont;
      end

      // Packet event from the link: choose the handshake and whether to store.
      mine = rxValid && (rxEp == 2'(e));
      if (mine) begin
        if (!cur.iso && cur.forceStall) begin
          s_d.hsValid = 1'b1;                                            // R13
          s_d.hsCode  = usb_out_ep_pkg::HsStall;
        end else if (cur.oversize) begin
          s_d.hsValid = !cur.iso;                                        // R2
          s_d.hsCode  = usb_out_ep_pkg::HsStall;
        end else if (rxBytes > cur.maxp) begin
          setSize     = 1'b1;                                            // R1
          s_d.hsValid = !cur.iso;                                        // R2
          s_d.hsCode  = usb_out_ep_pkg::HsStall;
        end else if (!cur.iso && rxBad) begin
          // A corrupt bulk packet gets no handshake at all, so the host retries.
          s_d.hsValid = 1'b0;
        end else if (full) begin
          setOvr      = cur.iso;                                         // R24
          s_d.hsValid = !cur.iso;
          s_d.hsCode  = usb_out_ep_pkg::HsNak;
        end else if (!cur.iso && rxToggle != cur.toggle) begin
          // Repeat of a packet whose ACK was lost: acknowledge, keep nothing.
          s_d.hsValid = 1'b1;
          s_d.hsCode  = usb_out_ep_pkg::HsAck;
        end else begin
          setErr      = cur.iso && rxBad;                                // R4
          s_d.hsValid = !cur.iso;
          s_d.hsCode  = usb_out_ep_pkg::HsAck;
          nxt.toggle  = cur.iso ? cur.toggle : !cur.toggle;
          base = 12'({cur.start, 6'h00})
               + (cur.wrSel ? 12'(bufLen) : 12'h000) + 12'(cur.wrCnt);  // R19 R20
          s_d.storeValid = 1'b1;
          s_d.storeEp    = 2'(e);
          s_d.storeAddr  = base;
          s_d.storeLen   = rxBytes;
          sum = 12'(cur.wrCnt) + 12'(rxBytes);
          if (cur.cont && !cur.iso) begin
            // Continuous bulk: the buffer closes when full or on a short packet.
            if (rxBytes < cur.maxp || sum >= 12'(bufLen)) begin         // R21
              push = 1'b1;
              len  = sum[10:0];
            end else begin
              nxt.wrCnt = sum[10:0];                                     // R21
            end
          end else begin
            push = 1'b1;
            len  = rxBytes;
          end
        end
      end

      // Byte reads count up toward the older buffer's length; the stored
      // length itself never counts down.
      if (fifoRead && fifoReadEp == 2'(e) && cur.nBuf != usb_out_ep_pkg::NBufZero) begin
        nxt.rdCnt = cur.rdCnt + 11'h001;                                 // R17
        if (cur.autoRel && (cur.rdCnt + 11'h001) >= cur.cnt0) begin
          pop = 1'b1;                                                    // R14
        end
      end
      if (relW && cur.nBuf != usb_out_ep_pkg::NBufZero) begin
        pop = 1'b1;                                                      // R5
      end

      // Pending discard drops the oldest buffer and then clears itself.
      if (cur.discardPend) begin
        if (cur.nBuf != usb_out_ep_pkg::NBufZero) begin
          pop = 1'b1;                                                    // R9 R10
        end
        nxt.discardPend = 1'b0;                                          // R11
      end
      if (ctrlW && wd[usb_out_ep_pkg::BitDiscard]) begin
        nxt.discardPend = 1'b1;
      end

      // Buffer queue: drop the oldest first, then append the new one.
      if (pop) begin
        nxt.nBuf  = nxt.nBuf - 2'h1;                                     // R5 R9 R10
        nxt.cnt0  = cur.cnt1;                                            // R18
        nxt.rdCnt = '0;
      end
      if (push) begin
        if (nxt.nBuf == usb_out_ep_pkg::NBufZero) begin
          nxt.cnt0 = len;                                                // R16
        end else begin
          nxt.cnt1 = len;                                                // R16 R18
        end
        nxt.nBuf  = nxt.nBuf + 2'h1;
        nxt.wrCnt = '0;
        nxt.wrSel = cur.dbl ? !cur.wrSel : 1'b0;
      end

      // Toggle initialise acts one cycle after the write and then clears.
      if (cur.togInitPend) begin
        nxt.toggle      = 1'b0;                                          // R6
        nxt.wrCnt       = '0;                                            // R6
        nxt.rdCnt       = '0;
        nxt.wrSel       = 1'b0;
        nxt.togInitPend = 1'b0;                                          // R7
      end
      if (ctrlW && wd[usb_out_ep_pkg::BitTogInit]) begin
        nxt.togInitPend = 1'b1;
      end

      // Sticky error flags; a set in the clearing cycle wins.
      nxt.overrun  = (cur.overrun && !clrOvr) || setOvr;                 // R3 R24 R25
      nxt.oversize = (cur.oversize && !clrSize) || setSize;              // R1 R3 R25
      nxt.dataErr  = (cur.dataErr && !clrErr) || setErr;                 // R3 R4 R25

      s_d.ep[e] = nxt;

      // Read data for the register being addressed, captured as ready rises.
      if (s_d.pready && mapped && !pwrite && regEp == 2'(e)) begin
        rd = '0;
        if (regSel == usb_out_ep_pkg::RegCtrl) begin
          rd[usb_out_ep_pkg::BitOccHigh:usb_out_ep_pkg::BitOccLow] =
            occ_code(cur.nBuf, cur.dbl);                                 // R23
          rd[usb_out_ep_pkg::BitOverrun]  = cur.overrun;
          rd[usb_out_ep_pkg::BitOversize] = cur.oversize;
          rd[usb_out_ep_pkg::BitDataErr]  = cur.dataErr;
          rd[usb_out_ep_pkg::BitTogInit]  = cur.togInitPend;
          rd[usb_out_ep_pkg::BitDiscard]  = cur.discardPend;
          rd[usb_out_ep_pkg::BitIso]      = cur.iso;
          rd[usb_out_ep_pkg::BitStall]    = cur.forceStall;
          rd[usb_out_ep_pkg::BitAutoRel]  = cur.autoRel;
          rd[usb_out_ep_pkg::BitToggle]   = cur.toggle;
        end else if (regSel == usb_out_ep_pkg::RegMaxp) begin
          rd[10:0] = cur.maxp;
        end else if (regSel == usb_out_ep_pkg::RegCount) begin
          rd[10:0] = cur.cnt0;                                           // R16 R18
        end else begin
          rd[usb_out_ep_pkg::LayStartHi:usb_out_ep_pkg::LayStartLo] = cur.start;
          rd[usb_out_ep_pkg::LaySizeHi:usb_out_ep_pkg::LaySizeLo]   = cur.size;
          rd[usb_out_ep_pkg::LayDouble] = cur.dbl;
          rd[usb_out_ep_pkg::LayCont]   = cur.cont;
        end
        s_d.prdata = {16'h0000, rd};
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Reset gives zero everywhere: empty FIFOs, bulk mode, DATA0 expected and a
  // maximum packet size of zero, so every packet with a payload is oversize until software
  // programs the endpoint.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;                                                         // R15
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata     = s_q.prdata;
  assign pready     = s_q.pready;
  assign pslverr    = s_q.pslverr;
  assign hsValid    = s_q.hsValid;
  assign hsCode     = s_q.hsCode;
  assign storeValid = s_q.storeValid;
  assign storeEp    = s_q.storeEp;
  assign storeAddr  = s_q.storeAddr;
  assign storeLen   = s_q.storeLen;

endmodule : usb_out_endpoint_receive_ctrl

`default_nettype wire

// [verif/usb_out_rx_sva.sv]
// Purpose: Port-level checks of the OUT endpoint receive control.
// Assumes: One clock domain with reset rstn, active low.
// Notes:   Most checks tie an output to its cause at the inputs; a_ready_one, a_read_idle and a_refuse_nostore check outputs alone.
`timescale 1ns/1ps
`default_nettype none
module usb_out_rx_sva (
  input wire logic        clk, rstn, pready, pslverr, rxValid, rxBad, hsValid, storeValid,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic [1:0]  rxEp, hsCode, storeEp,
  input wire logic [10:0] rxBytes, storeLen
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ready_one: assert property (pready |=> !pready) else $error("pready held too long");
  a_err_addr: assert property (pready |-> pslverr == (paddr >= 8'h40))
    else $error("pslverr does not follow the address");
  a_read_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not 0");
  a_hs_cause: assert property (hsValid |-> $past(rxValid))
    else $error("handshake without packet");
  a_store_cause: assert property (storeValid |-> $past(rxValid)) else $error("store without packet");
  a_store_len: assert property (storeValid |-> storeLen == $past(rxBytes)
    && storeEp == $past(rxEp)) else $error("store length or endpoint wrong");
  a_bad_noack: assert property (rxValid && rxBad |=> !(hsValid && hsCode == 2'h1))
    else $error("faulty packet acknowledged");
  a_refuse_nostore: assert property (hsValid && hsCode != 2'h1 |-> !storeValid)
    else $error("refused packet stored");
endmodule : usb_out_rx_sva
bind usb_out_endpoint_receive_ctrl usb_out_rx_sva u_usb_out_rx_sva (.clk, .rstn, .pready,
  .pslverr, .rxValid, .rxBad, .hsValid, .storeValid, .paddr, .prdata, .rxEp, .hsCode,
  .storeEp, .rxBytes, .storeLen);
`default_nettype wire

// [verif/usb_host_model.sv]
// Purpose: Host side that sends OUT packets and records the handshake.
// Assumes: One packet event per call, launched just after a clock edge.
// Notes:   Idle lines show the inverse of the last packet, never a stale copy.
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  input  wire logic        clk, hsValid,
  input  wire logic [1:0]  hsCode,
  output logic             rxValid, rxToggle, rxBad,
  output logic [1:0]       rxEp,
  output logic [10:0]      rxBytes
);
  logic [1:0] lastHs; // Handshake of the last packet, 0 when none came.
  initial {rxValid, rxToggle, rxBad, rxEp, rxBytes, lastHs} = '0;
  // One packet event, then the lines are scrambled and the reply is awaited.
  task automatic send(input logic [1:0] e, input logic t, input logic [10:0] b, input logic d);
    {rxValid, rxEp, rxToggle, rxBytes, rxBad, lastHs} <= {1'b1, e, t, b, d, 2'h0};
    @(posedge clk) {rxValid, rxEp, rxToggle, rxBytes, rxBad} <= {1'b0, ~e, ~t, ~b, ~d};
    repeat (2) @(posedge clk);
  endtask : send
  always @(posedge clk) if (hsValid) lastHs <= hsCode;
endmodule : usb_host_model
`default_nettype wire

// [verif/tb.sv]
// Purpose: Self-checking bench of the OUT endpoint receive control.
// Assumes: APB answers with pready; the host model stands at the link side.
// Notes:   Double buffering is left to later work.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, fifoRead = 0, pready, pslverr, er;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic rxValid, rxToggle, rxBad, hsValid, storeValid;
  logic [1:0] rxEp, hsCode, storeEp;
  logic [10:0] rxBytes, storeLen, sl;
  logic [11:0] storeAddr, sa;
  int failures = 0, samples_checked = 0, cyc = 0;
  always #20 clk = ~clk;
  usb_out_endpoint_receive_ctrl u_usb_out_endpoint_receive_ctrl (.clk, .rstn, .ce(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb(4'h3), .prdata, .pready, .pslverr, .rxValid,
    .rxEp, .rxToggle, .rxBytes, .rxBad, .fifoRead, .fifoReadEp(2'h0), .hsValid, .hsCode,
    .storeValid, .storeEp, .storeAddr, .storeLen);
  usb_host_model u_usb_host_model (.clk, .hsValid, .hsCode, .rxValid, .rxToggle, .rxBad,
    .rxEp, .rxBytes);
  always @(posedge clk) if (storeValid) {sa, sl} <= {storeAddr, storeLen};
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim;
    $display("checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      end_sim();
    end
  end
  // APB transfer: setup, access until pready, then release at that edge and idle one full cycle.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 9);
    if (n >= 9) failures++;
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask : bus
  task automatic rdf(input int n);
    repeat (n) begin fifoRead <= 1; @(posedge clk) fifoRead <= 0; @(posedge clk); end
  endtask : rdf
  task automatic s_reset;
    bus(0, 8'h04, 0); chk(rd, 0);
    bus(0, 8'h40, 0); chk(er, 1);
    bus(1, 8'h0c, 32'h0000_0045); bus(1, 8'h04, 32'h0000_0040);
    bus(1, 8'h00, 32'h0000_0200); bus(0, 8'h00, 0); chk(rd, 0);
  endtask : s_reset
  task automatic s_bulk;
    u_usb_host_model.send(0, 0, 10, 0); chk(u_usb_host_model.lastHs, 2'h1);
    chk(sa, 12'h140); chk(sl, 10); bus(0, 8'h00, 0); chk(rd, 32'h0000_4003);
    u_usb_host_model.send(0, 1, 8, 0); chk(u_usb_host_model.lastHs, 2'h2);
    rdf(3);
    bus(0, 8'h08, 0); chk(rd, 10);
    bus(1, 8'h00, 32'h0000_0020); bus(0, 8'h00, 0); chk(rd, 32'h0000_4000);
    u_usb_host_model.send(0, 0, 5, 0); bus(0, 8'h00, 0); chk(rd, 32'h0000_4000);
  endtask : s_bulk
  task automatic s_errors;
    u_usb_host_model.send(0, 1, 100, 0); chk(u_usb_host_model.lastHs, 2'h3);
    u_usb_host_model.send(0, 1, 10, 0); chk(u_usb_host_model.lastHs, 2'h3);
    bus(1, 8'h00, 0); bus(0, 8'h00, 0); chk(rd, 32'h0000_4008);
    bus(1, 8'h00, 32'h0000_0080); bus(0, 8'h00, 0); chk(rd, 32'h0000_4000);
    bus(1, 8'h00, 32'h0000_1000); u_usb_host_model.send(0, 1, 5, 0);
    chk(u_usb_host_model.lastHs, 2'h3); bus(1, 8'h00, 0);
    u_usb_host_model.send(0, 1, 5, 0); bus(0, 8'h08, 0); chk(rd, 5);
    bus(1, 8'h00, 32'h0000_2000); rdf(5); bus(0, 8'h00, 0); chk(rd, 32'h0000_2000);
  endtask : s_errors
  task automatic s_iso;
    bus(1, 8'h10, 32'h0000_0800); u_usb_host_model.send(1, 0, 0, 1);
    chk(u_usb_host_model.lastHs, 0); bus(0, 8'h10, 0); chk(rd & 32'h3fff, 32'h0813);
    u_usb_host_model.send(1, 0, 0, 0); bus(0, 8'h10, 0); chk(rd & 32'h3fff, 32'h0817);
    bus(1, 8'h10, 32'h0000_0c00); bus(1, 8'h10, 32'h0000_0940);
    bus(0, 8'h10, 0); chk(rd & 32'h3fff, 32'h0800);
  endtask : s_iso
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    s_reset(); s_bulk(); s_errors(); s_iso();
    end_sim();
  end
endmodule : tb
`default_nettype wire
